//--- hdl/tc_dma.sv
// four channel transfer controller with ahb-lite register slave
// Summary of operation
// R1 - requests only from on-chip peripherals or software
// R2 - obtain cpu bus mastership before transferring
// R3 - fixed priority, channel 0 highest, before first clock
// R4 - acknowledge during cycle touching requesting device
// R5 - on termination update flags, interrupt, release bus
// R6 - continuous policy keeps bus while request stays
// R7 - resample request after acknowledge drops, every clock
// R8 - four channels, eight registers each
// R9 - fixed primary/secondary request sources per channel
// R10 - software picks indirect for mismatched or memory ends
// R11 - direct mode: one bus cycle, data not captured
// R12 - direct: intermittent 1/3 clocks, continuous 1/clock
// R13 - direct address from a counter, direction picks read/write
// R14 - size bit picks 8 or 16 bits
// R15 - direct item: length minus one, adjust a counter
// R16 - indirect: read into holding register, then write
// R17 - indirect: intermittent 1/5 clocks, continuous 1/2
// R18 - indirect: direction picks which counter reads
// R19 - indirect item: length minus one, adjust both counters
// R20 - writing one to valid flag clears it
// R21 - length zero: stop, set tc and overrun, interrupt
// R22 - software disables channel before rewriting control
// R23 - debug halt stops all transfer activity; code blocks new items only, a started indirect item still runs its write
`include "tc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tc_dma
  import tc_pkg::*;
#(
  parameter int AW = 24,
  parameter int LW = 16
) (
  input  wire logic        clk,            // system clock
  input  wire logic        rst_n,          // synchronous reset, active low
  input  wire logic        hsel,           // ahb slave select
  input  wire logic [31:0] haddr,          // ahb address
  input  wire logic [1:0]  htrans,         // ahb transfer type
  input  wire logic        hwrite,         // ahb write
  input  wire logic [2:0]  hsize,          // ahb size, word only
  input  wire logic [31:0] hwdata,         // ahb write data
  input  wire logic        hready,         // ahb bus ready
  output logic      [31:0] hrdata,         // ahb read data
  output logic             hreadyout,      // ahb slave ready
  output logic             hresp,          // ahb response, always okay
  input  wire logic [3:0]  periph_req_pri, // primary on-chip requests
  input  wire logic [3:0]  periph_req_sec, // secondary on-chip requests
  output logic      [3:0]  dack,           // acknowledge per channel
  output logic      [3:0]  irq,            // interrupt level per channel
  input  wire logic        freeze,         // debug halt
  output logic             bus_req,        // cpu bus mastership request
  input  wire logic        bus_grant,      // cpu bus granted
  output logic             m_valid,        // bus cycle in progress
  output logic [AW-1:0]    m_addr,         // bus cycle address
  output logic             m_write,        // bus cycle is a write
  output logic             m_size16,       // 16 bit item, else 8
  output logic      [15:0] m_wdata,        // indirect write data
  input  wire logic [15:0] m_rdata,        // indirect read data
  input  wire logic        m_ready         // bus cycle completes
);
  tc_state_e state;
  tc_ch_t    cur;
  logic [AW-1:0] adca [4];
  logic [AW-1:0] adcb [4];
  logic [LW-1:0] bltc [4];
  logic [15:0]   cntl [4];
  logic [3:0]    channel_active, tcf, overrun_flag, vld;
  logic [3:0]    channel_request_line, pend;
  // ahb slave state
  logic        aw_valid, aw_write, rd_wait;
  tc_ch_t      aw_ch;
  logic [4:0]  aw_idx;
  logic [AW-1:0] rl_rdata;

  // request sources: on-chip lines or software only, no pin input
  wire [3:0] sec_present = `TC_SEC_MASK; // channel 1 has no secondary source
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_req
      assign channel_request_line[gi] = periph_req_pri[gi] // R1 R9
        | (periph_req_sec[gi] & sec_present[gi])
        | cntl[gi][`TC_CN_SWRQ];
      assign pend[gi] = cntl[gi][`TC_CN_CHANNEL_ENABLE] & (bltc[gi] != '0)
        & channel_request_line[gi];
    end
  endgenerate

  // fixed priority, lowest channel number wins
  wire       any_pend = |pend;
  wire tc_ch_t win = pend[0] ? 2'h0 : pend[1] ? 2'h1 : pend[2] ? 2'h2 : 2'h3; // R3

  // fields of the channel in service
  wire [15:0] cc    = cntl[cur];
  wire        c_ind = cc[`TC_CN_IND];
  wire        c_dir = cc[`TC_CN_DIR];
  wire        c_cont = cc[`TC_CN_CONT];
  wire [AW-1:0] step = cc[`TC_CN_TCS] ? AW'(2) : AW'(1); // R14

  // cycle completion and item bookkeeping
  wire done_cyc  = m_valid & m_ready;
  wire item_done = done_cyc & ((state == S_WR) | ((state == S_RD) & ~c_ind));
  wire last      = bltc[cur] == LW'(1);
  wire go_on     = ~last & c_cont & channel_request_line[cur] // R6 R7
    & cc[`TC_CN_CHANNEL_ENABLE] & ~freeze; // R23

  // adjusted counters, used for both update and relaunch address
  wire [AW-1:0] next_adca = (item_done & cc[`TC_CN_ADA])
    ? (cc[`TC_CN_STA] ? adca[cur] - step : adca[cur] + step) : adca[cur]; // R15 R19
  wire [AW-1:0] next_adcb = (item_done & c_ind & cc[`TC_CN_ADB])
    ? (cc[`TC_CN_STB] ? adcb[cur] - step : adcb[cur] + step) : adcb[cur]; // R19

  // launch values for a first (read) cycle on channel lch
  wire tc_ch_t  lch   = (state == S_GRANT) ? win : cur;
  wire [15:0]   lc    = cntl[lch];
  wire [AW-1:0] la    = (state == S_GRANT) ? adca[win] : next_adca;
  wire [AW-1:0] lb    = (state == S_GRANT) ? adcb[win] : next_adcb;
  wire          l_ind = lc[`TC_CN_IND];
  wire          l_dir = lc[`TC_CN_DIR];
  wire [AW-1:0] rd_addr = (l_ind & l_dir) ? lb : la; // R13 R18
  wire          rd_wr   = ~l_ind & l_dir; // R13
  wire [3:0]    rd_ack  = (~l_ind | ~l_dir) ? (4'h1 << lch) : 4'h0; // R4
  // second (write) cycle of an indirect item
  wire [AW-1:0] wr_addr = c_dir ? adca[cur] : adcb[cur]; // R18
  wire [3:0]    wr_ack  = c_dir ? (4'h1 << cur) : 4'h0; // R4

  // bus master sequencer; freeze blocks every new item, but a started indirect item still runs its write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state    <= S_IDLE;
      cur      <= 2'h0;
      bus_req  <= 1'b0;
      m_valid  <= 1'b0;
      m_addr   <= '0;
      m_write  <= 1'b0;
      m_size16 <= 1'b0;
      m_wdata  <= 16'h0;
      dack     <= 4'h0;
    end else begin
      case (state)
        S_IDLE: begin
          if (any_pend && !freeze) begin // R2 R23
            bus_req <= 1'b1;
            state   <= S_GRANT;
          end
        end
        S_GRANT: begin
          if (bus_grant && any_pend && !freeze) begin // R2 R3
            cur      <= win;
            state    <= S_RD;
            m_valid  <= 1'b1;
            m_addr   <= rd_addr;
            m_write  <= rd_wr;
            m_size16 <= lc[`TC_CN_TCS]; // R14
            dack     <= rd_ack;
          end else if (!any_pend) begin
            bus_req <= 1'b0;
            state   <= S_IDLE;
          end
        end
        S_RD: begin
          if (done_cyc && c_ind) begin // R16
            state   <= S_WR;
            m_addr  <= wr_addr;
            m_write <= 1'b1;
            m_wdata <= m_rdata;
            dack    <= wr_ack;
          end else if (done_cyc && go_on) begin // R11 R12
            m_addr  <= rd_addr;
            m_write <= rd_wr;
            dack    <= rd_ack;
          end else if (done_cyc) begin // R5 R12
            state   <= S_IDLE;
            m_valid <= 1'b0;
            bus_req <= 1'b0;
            dack    <= 4'h0;
          end
        end
        S_WR: begin
          if (done_cyc && go_on) begin // R17
            state   <= S_RD;
            m_addr  <= rd_addr;
            m_write <= rd_wr;
            dack    <= rd_ack;
          end else if (done_cyc) begin // R5 R17
            state   <= c_cont ? S_IDLE : S_REL;
            m_valid <= 1'b0;
            bus_req <= 1'b0;
            dack    <= 4'h0;
          end
        end
        S_REL: state <= S_IDLE; // spaces intermittent indirect items to five clocks
        default: state <= S_IDLE;
      endcase
    end
  end

  // ahb decode of the address and data phases
  wire        ap      = hsel & htrans[1] & hready;
  wire        wr_en   = aw_valid & aw_write;
  wire [4:0]  ridx    = haddr[6:2];
  wire [1:0]  rslot   = (ridx == `TC_IDX_ADRB) ? `TC_RL_ADRB
    : (ridx == `TC_IDX_BLTR) ? `TC_RL_BLTR : `TC_RL_ADRA;
  wire [1:0]  wslot   = (aw_idx == `TC_IDX_ADRB) ? `TC_RL_ADRB
    : (aw_idx == `TC_IDX_BLTR) ? `TC_RL_BLTR : `TC_RL_ADRA;
  wire        rl_we   = wr_en & ((aw_idx == `TC_IDX_ADRA) | (aw_idx == `TC_IDX_ADRB)
    | (aw_idx == `TC_IDX_BLTR));
  wire [15:0] st_word = {12'h0, vld[aw_ch], overrun_flag[aw_ch], tcf[aw_ch], channel_active[aw_ch]};
  wire [31:0] rmux;
  assign rmux = (aw_idx == `TC_IDX_ADCA) ? 32'(adca[aw_ch])
    : (aw_idx == `TC_IDX_ADCB) ? 32'(adcb[aw_ch])
    : (aw_idx == `TC_IDX_BLTC) ? 32'(bltc[aw_ch])
    : (aw_idx == `TC_IDX_ADRA || aw_idx == `TC_IDX_ADRB) ? 32'(rl_rdata)
    : (aw_idx == `TC_IDX_BLTR) ? 32'(rl_rdata[LW-1:0])
    : (aw_idx == `TC_IDX_CNTL) ? 32'(cntl[aw_ch])
    : (aw_idx == `TC_IDX_STAT) ? 32'(st_word)
    : 32'h0; // unmapped reads as zero

  // reload registers live in their own memory, one wait state on reads
  tc_reload_mem #(.W(AW), .AW(4)) u_reload (
    .clk   (clk),
    .we    (rl_we),
    .waddr ({aw_ch, wslot}),
    .wdata (hwdata[AW-1:0]),
    .raddr ({haddr[8:7], rslot}),
    .rdata (rl_rdata)
  );

  // ahb slave: zero-wait writes, one-wait reads
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_valid  <= 1'b0;
      aw_write  <= 1'b0;
      aw_ch     <= 2'h0;
      aw_idx    <= 5'h0;
      rd_wait   <= 1'b0;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (rd_wait) begin
      rd_wait   <= 1'b0;
      hrdata    <= rmux;
      hreadyout <= 1'b1;
    end else if (hready) begin
      aw_valid  <= ap;
      aw_write  <= hwrite;
      aw_ch     <= haddr[8:7];
      aw_idx    <= haddr[6:2];
      rd_wait   <= ap & ~hwrite;
      hreadyout <= ~(ap & ~hwrite);
    end
  end

  // per channel counters, control and status (four identical sets)
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ch
      wire sel  = wr_en & (aw_ch == tc_ch_t'(gi)); // R8
      wire upd  = item_done & (cur == tc_ch_t'(gi));
      wire term = upd & last;
      wire wst  = sel & (aw_idx == `TC_IDX_STAT);
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          adca[gi] <= '0;
          adcb[gi] <= '0;
          bltc[gi] <= '0;
          cntl[gi] <= 16'h0;
        end else if (upd) begin // R15 R19
          adca[gi] <= next_adca;
          adcb[gi] <= next_adcb;
          bltc[gi] <= bltc[gi] - LW'(1);
        end else begin
          if (sel && aw_idx == `TC_IDX_ADCA) adca[gi] <= hwdata[AW-1:0];
          if (sel && aw_idx == `TC_IDX_ADCB) adcb[gi] <= hwdata[AW-1:0];
          if (sel && aw_idx == `TC_IDX_BLTC) bltc[gi] <= hwdata[LW-1:0];
          if (sel && aw_idx == `TC_IDX_CNTL) cntl[gi] <= hwdata[15:0] & `TC_CN_MASK;
        end
      end
      // sticky flags: a hardware set wins over a write-one clear
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          tcf[gi]  <= 1'b0;
          overrun_flag[gi]  <= 1'b0;
          vld[gi]  <= 1'b0;
          channel_active[gi] <= 1'b0;
          irq[gi]  <= 1'b0;
        end else begin
          tcf[gi] <= term | (tcf[gi] & ~(wst & hwdata[`TC_ST_TC])); // R21
          overrun_flag[gi] <= term | (overrun_flag[gi] & ~(wst & hwdata[`TC_ST_OVR])); // R21
          vld[gi] <= (sel & aw_idx == `TC_IDX_BLTR)
            | (vld[gi] & ~(wst & hwdata[`TC_ST_VLD])); // R20
          if (term) begin
            channel_active[gi] <= 1'b0; // R21
          end else if (sel && aw_idx == `TC_IDX_CNTL) begin
            channel_active[gi] <= hwdata[`TC_CN_CHANNEL_ENABLE];
          end
          irq[gi] <= (tcf[gi] & cntl[gi][`TC_CN_ETC])
            | (overrun_flag[gi] & cntl[gi][`TC_CN_OVERRUN_IRQ_ENABLE]); // R5 R21
        end
      end
    end
  endgenerate

  // checks next to the sequencer
  sequence s_ind_read_done;
    (state == S_RD) && done_cyc && c_ind;
  endsequence
  sequence s_ind_write;
    m_valid && m_write && (state == S_WR);
  endsequence

  AST_MASTER_FIRST: assert property (@(posedge clk) disable iff (!rst_n) // R2
    m_valid |-> bus_req) else $error("bus cycle without mastership request");
  AST_PRIO_CH0: assert property (@(posedge clk) disable iff (!rst_n) // R3
    (state == S_GRANT && bus_grant && !freeze && pend[0]) |=> (m_valid && cur == 2'h0))
    else $error("channel 0 not chosen first");
  AST_ACK_IN_CYCLE: assert property (@(posedge clk) disable iff (!rst_n) // R4
    (dack != 4'h0) |-> m_valid) else $error("acknowledge outside bus cycle");
  AST_TERM_FLAGS: assert property (@(posedge clk) disable iff (!rst_n) // R21
    (item_done && last) |=> (tcf[$past(cur)] && overrun_flag[$past(cur)] && !channel_active[$past(cur)]))
    else $error("termination flags not updated");
  AST_TERM_RELEASE: assert property (@(posedge clk) disable iff (!rst_n) // R5
    (item_done && last) |=> (!m_valid && !bus_req)) else $error("bus kept after end");
  AST_DIR_INTERMIT: assert property (@(posedge clk) disable iff (!rst_n) // R12
    (done_cyc && state == S_RD && !c_ind && !c_cont) |=> !m_valid [*2])
    else $error("intermittent direct too fast");
  AST_IND_WRITE: assert property (@(posedge clk) disable iff (!rst_n) // R16
    s_ind_read_done |=> s_ind_write ##0 (m_wdata == $past(m_rdata)))
    else $error("indirect write does not follow read");
  AST_LEN_DEC: assert property (@(posedge clk) disable iff (!rst_n) // R15
    (item_done && !last) |=> (bltc[$past(cur)] == $past(bltc[cur]) - LW'(1)))
    else $error("length counter not decremented");
  AST_DIRECT_ADDR: assert property (@(posedge clk) disable iff (!rst_n) // R13
    (m_valid && state == S_RD && !c_ind) |-> (m_addr == adca[cur] && m_write == c_dir))
    else $error("direct cycle address or direction wrong");
  AST_FREEZE: assert property (@(posedge clk) disable iff (!rst_n) // R23
    (freeze && state == S_IDLE) |=> state == S_IDLE) else $error("activity during halt");
  AST_VLD_CLEAR: assert property (@(posedge clk) disable iff (!rst_n) // R20
    (wr_en && aw_idx == `TC_IDX_STAT && hwdata[`TC_ST_VLD]
      && aw_idx != `TC_IDX_BLTR) |=> !vld[$past(aw_ch)])
    else $error("valid flag not cleared by write one");
endmodule : tc_dma
`default_nettype wire

//--- hdl/tc_consts.svh
// register indices, field positions and masks of the transfer controller
`ifndef TC_CONSTS_SVH
`define TC_CONSTS_SVH
// register indices inside one channel; byte address is index times four
`define TC_IDX_ADCA 5'h00
`define TC_IDX_ADRA 5'h04
`define TC_IDX_ADCB 5'h08
`define TC_IDX_ADRB 5'h0c
`define TC_IDX_BLTC 5'h10
`define TC_IDX_BLTR 5'h14
`define TC_IDX_CNTL 5'h1c
`define TC_IDX_STAT 5'h1e
// reload memory slot per register
`define TC_RL_ADRA 2'h0
`define TC_RL_ADRB 2'h1
`define TC_RL_BLTR 2'h2
// channel_control_reg fields
`define TC_CN_CHANNEL_ENABLE 0
`define TC_CN_SWRQ 1
`define TC_CN_DIR 2
`define TC_CN_TCS 3
`define TC_CN_IND 4
`define TC_CN_CONT 5
`define TC_CN_ADA 6
`define TC_CN_ADB 7
`define TC_CN_STA 8
`define TC_CN_STB 9
`define TC_CN_OT 10
`define TC_CN_ETC 11
`define TC_CN_OVERRUN_IRQ_ENABLE 12
`define TC_CN_MASK 16'h1fff
// channel_status_reg fields
`define TC_ST_CHANNEL_ACTIVE 0
`define TC_ST_TC 1
`define TC_ST_OVR 2
`define TC_ST_VLD 3
// secondary request source present per channel (channel 1 has none)
`define TC_SEC_MASK 4'hd
`endif

//--- hdl/tc_pkg.sv
// types shared by the transfer controller files
package tc_pkg;
  typedef enum logic [2:0] {S_IDLE, S_GRANT, S_RD, S_WR, S_REL} tc_state_e;
  typedef logic [1:0] tc_ch_t;
endpackage : tc_pkg

//--- hdl/tc_reload_mem.sv
// small reload register memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module tc_reload_mem #(
  parameter int W  = 24,
  parameter int AW = 4
) (
  input  wire logic          clk,   // system clock
  input  wire logic          we,    // write strobe
  input  wire logic [AW-1:0] waddr, // write slot
  input  wire logic [W-1:0]  wdata, // write data
  input  wire logic [AW-1:0] raddr, // read slot
  output logic      [W-1:0]  rdata  // read data, one cycle later
);
  logic [W-1:0] mem [2**AW];

  // no reset: contents are software's job before first use
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : tc_reload_mem
`default_nettype wire

//--- verification/tc_bus_model.sv
// cpu bus arbiter and memory model facing the transfer controller master port
`timescale 1ns/1ps
`default_nettype none
module tc_bus_model (
  input  wire logic        clk,       // system clock
  input  wire logic        rst_n,     // synchronous reset, active low
  input  wire logic        slow,      // stretch grants and cycles at random
  input  wire logic        bus_req,   // mastership request
  output logic             bus_grant, // mastership granted
  input  wire logic        m_valid,   // cycle in progress
  input  wire logic [23:0] m_addr,    // cycle address
  input  wire logic        m_write,   // cycle is a write
  output logic             m_ready,   // cycle completes
  output logic      [15:0] m_rdata    // read data
);
  logic        coin;
  logic [15:0] junk;
  // grant only while asked, one edge late at best, later when slow
  always_ff @(posedge clk) begin
    coin      <= 1'($urandom_range(1, 0));
    bus_grant <= rst_n && bus_req && (!slow || coin);
    junk      <= rst_n ? m_rdata : 16'h0;
  end
  // released data lines keep changing so a stale value never looks valid
  assign m_ready = m_valid && (!slow || coin);
  assign m_rdata = (m_valid && !m_write) ? (m_addr[15:0] ^ 16'ha5c3) : ~junk;
endmodule : tc_bus_model
`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench for the four channel transfer controller
`include "tc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tc_pkg::*;
  logic        clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, freeze, slow;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  req_pri, req_sec, dack, irq;
  logic        bus_req, bus_grant, m_valid, m_write, m_size16, m_ready;
  logic        rd_ph = 1'b0;
  logic [23:0] m_addr;
  logic [15:0] m_wdata, m_rdata;
  logic [31:0] rq[$];
  logic [47:0] bq[$];
  int          mismatches = 0;
  int          tests_run = 0;

  assign hready = hreadyout; // one slave, its ready is the bus ready
  tc_dma tc_dma_i (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .periph_req_pri(req_pri),
    .periph_req_sec(req_sec), .dack(dack), .irq(irq), .freeze(freeze),
    .bus_req(bus_req), .bus_grant(bus_grant), .m_valid(m_valid), .m_addr(m_addr),
    .m_write(m_write), .m_size16(m_size16), .m_wdata(m_wdata), .m_rdata(m_rdata),
    .m_ready(m_ready));
  tc_bus_model tc_bus_model_i (
    .clk(clk), .rst_n(rst_n), .slow(slow), .bus_req(bus_req), .bus_grant(bus_grant),
    .m_valid(m_valid), .m_addr(m_addr), .m_write(m_write), .m_ready(m_ready),
    .m_rdata(m_rdata));

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done

  // one single word transfer; address phase held until ready, then data phase
  task automatic ahb(input logic w, input logic [1:0] ch, input logic [4:0] idx,
                     input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {23'h0, ch, idx, 2'h0};
    do @(posedge clk); while (!hreadyout);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (!hreadyout);
  endtask : ahb

  task automatic wr(input logic [1:0] ch, input logic [4:0] idx, input logic [31:0] d);
    ahb(1'b1, ch, idx, d);
  endtask : wr

  task automatic rd(input logic [1:0] ch, input logic [4:0] idx, input logic [31:0] e);
    rq.push_back(e);
    ahb(1'b0, ch, idx, $urandom);
  endtask : rd

  // note one master cycle: write-data check, ack check, ack, write, size, address, data
  task automatic cyc(input logic cw, input logic cd, input logic [3:0] ack, input logic w,
                     input logic sz, input logic [23:0] a, input logic [15:0] d);
    bq.push_back({cw, cd, ack, w, sz, a, d});
  endtask : cyc

  // bounded wait until every noted cycle ran and the bus went back
  task automatic settle();
    int n;
    n = 0;
    while ((bq.size() != 0 || bus_req !== 1'b0) && n < 500) begin
      @(posedge clk);
      n++;
    end
    repeat (4) @(posedge clk);
    check(bq.size(), 32'h0, "cycles still owed");
    check({31'h0, bus_req}, 32'h0, "bus still held");
  endtask : settle

  // scoreboard: each finished read or master cycle takes the oldest note
  always @(posedge clk) begin
    logic [47:0] e;
    if (rst_n && rd_ph && hreadyout) begin
      check(hrdata, rq.pop_front(), "register read");
      check({31'h0, hresp}, 32'h0, "response");
    end
    if (rst_n && m_valid && m_ready) begin
      e = bq.pop_front();
      check({6'h0, m_write, m_size16, m_addr}, {6'h0, e[41:16]}, "cycle kind");
      if (e[46]) check({28'h0, dack}, {28'h0, e[45:42]}, "acknowledge");
      if (e[47]) check({16'h0, m_wdata}, {16'h0, e[15:0]}, "write data");
    end
    rd_ph <= rst_n && (hsel && htrans[1] && hready && !hwrite || rd_ph && !hreadyout);
  end

  task automatic run_regs();
    logic [31:0] d;
    d = $urandom;
    rd(2'h2, `TC_IDX_CNTL, 32'h0);
    rd(2'h2, `TC_IDX_STAT, 32'h0);
    wr(2'h3, `TC_IDX_ADCA, d);
    rd(2'h3, `TC_IDX_ADCA, {8'h0, d[23:0]});
    wr(2'h3, `TC_IDX_CNTL, 32'hfffffffc);
    rd(2'h3, `TC_IDX_CNTL, 32'h1ffc);
    wr(2'h3, `TC_IDX_CNTL, 32'h0);
    wr(2'h3, `TC_IDX_BLTR, d);
    rd(2'h3, `TC_IDX_BLTR, {16'h0, d[15:0]});
    rd(2'h3, `TC_IDX_STAT, 32'h8);
    wr(2'h3, `TC_IDX_STAT, 32'h8);
    rd(2'h3, `TC_IDX_STAT, 32'h0);
    wr(2'h3, 5'h18, 32'hffffffff);
    rd(2'h3, 5'h18, 32'h0);
  endtask : run_regs

  // s=0: 16 bit, increment, intermittent; s=1: 8 bit, decrement, continuous, slow bus
  task automatic run_direct(input logic s);
    logic [23:0] a;
    a = (24'($urandom) & 24'h00fff0) | 24'h000100;
    slow <= s;
    wr(2'h0, `TC_IDX_ADCA, {8'h0, a});
    wr(2'h0, `TC_IDX_BLTC, 32'h3);
    wr(2'h0, `TC_IDX_STAT, 32'hf);
    for (int i = 0; i < 3; i++) begin
      cyc(1'b0, 1'b1, 4'h1, 1'b0, !s, s ? a - 24'(i) : a + 24'(2 * i), 16'h0);
    end
    wr(2'h0, `TC_IDX_CNTL, s ? 32'h0961 : 32'h0849);
    if (s) req_sec <= 4'h1;
    else req_pri <= 4'h1;
    settle();
    req_pri <= 4'h0;
    req_sec <= 4'h0;
    rd(2'h0, `TC_IDX_STAT, 32'h6);
    rd(2'h0, `TC_IDX_BLTC, 32'h0);
    rd(2'h0, `TC_IDX_ADCA, {8'h0, s ? a - 24'h3 : a + 24'h6});
    check({28'h0, irq}, 32'h1, "terminal interrupt");
    wr(2'h0, `TC_IDX_STAT, 32'h6);
    repeat (2) @(posedge clk);
    check({28'h0, irq}, 32'h0, "interrupt cleared");
    wr(2'h0, `TC_IDX_CNTL, 32'h0);
  endtask : run_direct

  task automatic run_indirect();
    logic [23:0] a, b;
    a = 24'h004000;
    b = 24'h008000 | (24'($urandom) & 24'h000ff0);
    slow <= 1'b1;
    wr(2'h1, `TC_IDX_ADCA, {8'h0, a});
    wr(2'h1, `TC_IDX_ADCB, {8'h0, b});
    wr(2'h1, `TC_IDX_BLTC, 32'h2);
    for (int i = 0; i < 2; i++) begin
      cyc(1'b0, 1'b1, 4'h0, 1'b0, 1'b1, b - 24'(2 * i), 16'h0);
      cyc(1'b1, 1'b1, 4'h2, 1'b1, 1'b1, a + 24'(2 * i),
          (b[15:0] - 16'(2 * i)) ^ 16'ha5c3);
    end
    wr(2'h1, `TC_IDX_CNTL, 32'h2ff);
    settle();
    rd(2'h1, `TC_IDX_ADCA, {8'h0, a + 24'h4});
    rd(2'h1, `TC_IDX_ADCB, {8'h0, b - 24'h4});
    rd(2'h1, `TC_IDX_STAT, 32'h6);
    check({28'h0, irq}, 32'h0, "interrupt while disabled");
    wr(2'h1, `TC_IDX_CNTL, 32'h0);
  endtask : run_indirect

  task automatic run_priority();
    slow <= 1'b0;
    for (int c = 2; c < 4; c++) begin
      wr(2'(c), `TC_IDX_ADCA, 32'h100 * c);
      wr(2'(c), `TC_IDX_BLTC, 32'h1);
      wr(2'(c), `TC_IDX_CNTL, 32'h1);
    end
    freeze  <= 1'b1;
    req_pri <= 4'hc;
    repeat (10) @(posedge clk);
    check({31'h0, bus_req}, 32'h0, "request under halt");
    cyc(1'b0, 1'b1, 4'h4, 1'b0, 1'b0, 24'h000200, 16'h0);
    cyc(1'b0, 1'b1, 4'h8, 1'b0, 1'b0, 24'h000300, 16'h0);
    freeze <= 1'b0;
    settle();
    req_pri <= 4'h0;
    for (int c = 2; c < 4; c++) wr(2'(c), `TC_IDX_CNTL, 32'h0);
  endtask : run_priority

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // watchdog: the whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("CHECK FAILED at %0t: run hung", $time);
    test_done();
  end

  initial begin
    {rst_n, hsel, hwrite, freeze, slow} = '0;
    {haddr, hwdata, htrans, req_pri, req_sec} = '0;
    hsize = 3'h2;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    void'($urandom(28451));
    run_regs();
    $display("test registers done");
    run_direct(1'b0);
    run_direct(1'b1);
    $display("test direct done");
    run_indirect();
    $display("test indirect done");
    run_priority();
    $display("test priority done");
    test_done();
  end
endmodule : tb_top
`default_nettype wire
